//--- ccnop_regs.svh
// Timing constants for the clock-change and NOP sequencer.
// Assumes a 250 MHz controller clock; included by bare name.
`ifndef CCNOP_REGS_SVH
`define CCNOP_REGS_SVH
`define CCNOP_CLK_PS 4000
`define CCNOP_TXP_NS 8
`define CCNOP_TXP_CYC ((`CCNOP_TXP_NS * 1000 + `CCNOP_CLK_PS - 1) / `CCNOP_CLK_PS)
`define CCNOP_STABLE_TCK 2
`define CCNOP_NOP_CA 3'h7
`define CCNOP_ON 1'h1
`define CCNOP_OFF 1'h0
`endif

//--- ccnop_pkg.sv
// Types for the clock-change and NOP sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package ccnop_pkg;
   typedef enum logic [4:0]
   {
      CCNOP_RUN = 5'h01,
      CCNOP_DRAIN = 5'h02,
      CCNOP_STOP = 5'h04,
      CCNOP_STABLE = 5'h08,
      CCNOP_EXIT = 5'h10
   } ccnop_state_t;
endpackage : ccnop_pkg

//--- ccnop_cnt.sv
// Down counter that raises done when loaded count elapses.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps
module ccnop_cnt #(
   parameter int W = 8
) (
   input wire logic clk, // Clock
   input wire logic nrst, // Sync reset, low
   input wire logic load, // Load pulse
   input wire logic [W-1:0] value, // Cycles to count
   output logic done // Count elapsed
);
   logic [W-1:0] cnt_ff;
   // Count down to zero after load
   always_ff @(posedge clk)
   begin
      if (!nrst)
         cnt_ff <= '0;
      else if (load)
         cnt_ff <= value;
      else if (cnt_ff != '0)
         cnt_ff <= cnt_ff - 1'b1;
   end
   assign done = (cnt_ff == '0) && !load;
endmodule : ccnop_cnt

//--- ccnop_ctrl.sv
// Host-side sequencer for clock stop / frequency change with CKE high.
// Assumes a command engine upstream reporting idle and refresh state.
//
// Functional notes
// [R1] Clock change only while refresh obligations are satisfied.
// [R2] All array, mode commands and bursts finished before the change.
// [R3] Command timing parameters expire before the clock is altered.
// [R4] Chip select held high throughout the change.
// [R5] Only all-bank refresh may stay in progress meanwhile.
// [R6] No valid command until clock stable 2 tCK plus tXP.
// [R7] Each clock period stays within min and max limits.
// [R8] Reprogram latency settings by mode writes after frequency change.
// [R9] Stopped clock holds CK low and CK# high.
// [R10] NOP only when CKE is the same in previous and current cycle.
// [R11] Device decodes NOP from CS# high, or CS# low with CA0..2 high.
// [R12] A NOP never cuts short an operation already in progress.
// [R13] Device keeps its state while the clock is stopped.
`timescale 1ns/1ps
`include "ccnop_regs.svh"
module ccnop_ctrl #(
   parameter int TXP_CYC = `CCNOP_TXP_CYC,
   parameter int STABLE_TCK = `CCNOP_STABLE_TCK,
   parameter int CW = 8
) (
   input wire logic clk, // Controller clock
   input wire logic nrst, // Sync reset, low
   input wire logic chg_req, // Request clock stop or change
   input wire logic chg_done, // Clock resumed at new rate
   input wire logic refresh_ok, // Refresh obligations met
   input wire logic cmds_idle, // No commands or bursts pending
   input wire logic timing_met, // Command timers expired
   input wire logic only_refab, // At most an all-bank refresh running
   input wire logic ck_period_ok, // Clock generator period in range
   input wire logic user_valid, // User command valid
   input wire logic user_cs_n, // User chip select, low
   input wire logic [9:0] user_ca, // User command/address
   input wire logic user_cke, // User CKE level
   output logic user_ready, // User command accepted
   output logic ck_run, // Clock generator enable
   output logic ck_t, // Stopped-clock true level
   output logic ck_c, // Stopped-clock complement level
   output logic cs_n, // Chip select to device, low
   output logic [9:0] ca, // Command/address to device
   output logic cke, // CKE to device
   output logic mrw_req, // Request mode-setting rewrite
   output logic busy // Change sequence active
);
   ccnop_pkg::ccnop_state_t state_ff, nxt_state;
   logic stab_load, stab_done, exit_load, exit_done;
   logic safe;
   logic done_s1_ff, done_s2_ff, per_s1_ff, per_s2_ff;
   logic [CW-1:0] since_ck_ff;

   // ==========================================================
   // Entry conditions
   assign safe = refresh_ok && cmds_idle && timing_met && only_refab; // [R1] [R2] [R3] [R5]

   // ==========================================================
   // Two-flop synchronisers for clock generator status
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         done_s1_ff <= `CCNOP_OFF;
         done_s2_ff <= `CCNOP_OFF;
         per_s1_ff <= `CCNOP_OFF;
         per_s2_ff <= `CCNOP_OFF;
      end
      else
      begin
         done_s1_ff <= chg_done;
         done_s2_ff <= done_s1_ff;
         per_s1_ff <= ck_period_ok;
         per_s2_ff <= per_s1_ff; // [R7]
      end
   end

   // ==========================================================
   // Sequencer state
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ccnop_pkg::CCNOP_RUN:
            if (chg_req)
               nxt_state = ccnop_pkg::CCNOP_DRAIN;
         ccnop_pkg::CCNOP_DRAIN:
            if (safe)
               nxt_state = ccnop_pkg::CCNOP_STOP; // [R1] [R2] [R3] [R5]
         ccnop_pkg::CCNOP_STOP:
            if (done_s2_ff && per_s2_ff)
               nxt_state = ccnop_pkg::CCNOP_STABLE; // [R7]
         ccnop_pkg::CCNOP_STABLE:
            if (stab_done && !stab_load)
               nxt_state = ccnop_pkg::CCNOP_EXIT;
         ccnop_pkg::CCNOP_EXIT:
            if (exit_done && !exit_load)
               nxt_state = ccnop_pkg::CCNOP_RUN; // [R6]
         default:
            nxt_state = ccnop_pkg::CCNOP_RUN;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         state_ff <= ccnop_pkg::CCNOP_RUN;
      else
         state_ff <= nxt_state;
   end

   assign stab_load = (state_ff == ccnop_pkg::CCNOP_STOP) &&
                      (nxt_state == ccnop_pkg::CCNOP_STABLE);
   assign exit_load = (state_ff == ccnop_pkg::CCNOP_STABLE) &&
                      (nxt_state == ccnop_pkg::CCNOP_EXIT);

   // ==========================================================
   // Stable-clock and exit-latency timers
   ccnop_cnt #(.W(CW)) u_stab (
      .clk(clk),
      .nrst(nrst),
      .load(stab_load),
      .value(CW'(STABLE_TCK)),
      .done(stab_done)
   );
   ccnop_cnt #(.W(CW)) u_exit (
      .clk(clk),
      .nrst(nrst),
      .load(exit_load),
      .value(CW'(TXP_CYC)),
      .done(exit_done)
   );

   // ==========================================================
   // Clock control: stopped means CK low, CK# high
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ck_run <= `CCNOP_ON;
         ck_t <= `CCNOP_OFF;
         ck_c <= `CCNOP_ON;
      end
      else
      begin
         ck_run <= (nxt_state != ccnop_pkg::CCNOP_STOP); // [R7]
         ck_t <= `CCNOP_OFF; // [R9]
         ck_c <= `CCNOP_ON; // [R9]
      end
   end

   // ==========================================================
   // Command pins: user path in RUN, NOP with CS# high otherwise
   assign user_ready = (state_ff == ccnop_pkg::CCNOP_RUN) && !chg_req &&
                       (user_cke == cke); // [R10]

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cs_n <= `CCNOP_ON;
         ca <= '0;
         cke <= `CCNOP_ON;
      end
      else
      begin
         if (user_valid && user_ready)
         begin
            cs_n <= user_cs_n;
            ca <= user_ca;
            cke <= user_cke;
         end
         else
         begin
            cs_n <= `CCNOP_ON; // [R4] [R6] [R11]
            ca <= {7'h00, `CCNOP_NOP_CA}; // [R11] [R12]
         end
      end
   end

   // ==========================================================
   // Status and mode-rewrite request
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         busy <= `CCNOP_OFF;
         mrw_req <= `CCNOP_OFF;
      end
      else
      begin
         busy <= (nxt_state != ccnop_pkg::CCNOP_RUN); // [R13]
         mrw_req <= (state_ff == ccnop_pkg::CCNOP_EXIT) &&
                    (nxt_state == ccnop_pkg::CCNOP_RUN); // [R8]
      end
   end

   // ==========================================================
   // Checks
   property p_cs_high;
      @(posedge clk) disable iff (!nrst)
      (state_ff != ccnop_pkg::CCNOP_RUN) |=> cs_n;
   endproperty
   a_cs_high: assert property (p_cs_high) else $error("cs_n low during change"); // [R4]

   property p_safe_entry;
      @(posedge clk) disable iff (!nrst)
      (state_ff == ccnop_pkg::CCNOP_DRAIN) && (nxt_state == ccnop_pkg::CCNOP_STOP)
      |-> refresh_ok && cmds_idle && timing_met;
   endproperty
   a_safe_entry: assert property (p_safe_entry) else $error("unsafe entry"); // [R1]

   property p_idle_entry;
      @(posedge clk) disable iff (!nrst)
      $rose(state_ff == ccnop_pkg::CCNOP_STOP) |-> $past(cmds_idle) && $past(only_refab);
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("busy entry"); // [R2]

   property p_timing;
      @(posedge clk) disable iff (!nrst)
      $rose(state_ff == ccnop_pkg::CCNOP_STOP) |-> $past(timing_met);
   endproperty
   a_timing: assert property (p_timing) else $error("timing not met"); // [R3]

   property p_stop_clk;
      @(posedge clk) disable iff (!nrst)
      (state_ff == ccnop_pkg::CCNOP_STOP) |-> !ck_run && !ck_t && ck_c;
   endproperty
   a_stop_clk: assert property (p_stop_clk) else $error("clock not parked"); // [R9]

   property p_exit_wait;
      @(posedge clk) disable iff (!nrst)
      $rose(state_ff == ccnop_pkg::CCNOP_STABLE) |-> !user_ready [*3];
   endproperty
   a_exit_wait: assert property (p_exit_wait) else $error("early command"); // [R6]

   property p_cke_const;
      @(posedge clk) disable iff (!nrst)
      cke == $past(cke);
   endproperty
   a_cke_const: assert property (p_cke_const) else $error("cke changed"); // [R10]

   property p_mrw;
      @(posedge clk) disable iff (!nrst)
      $fell(busy) |-> mrw_req;
   endproperty
   a_mrw: assert property (p_mrw) else $error("no mode rewrite"); // [R8]

   // Cycles since the clock was re-enabled, saturating
   always_ff @(posedge clk)
   begin
      if (!nrst)
         since_ck_ff <= '0;
      else if (!ck_run)
         since_ck_ff <= '0;
      else if (since_ck_ff != '1)
         since_ck_ff <= since_ck_ff + 1'b1;
   end

   property p_drain_hold;
      @(posedge clk) disable iff (!nrst)
      (state_ff == ccnop_pkg::CCNOP_DRAIN) && !refresh_ok |=>
         ck_run && (state_ff == ccnop_pkg::CCNOP_DRAIN);
   endproperty
   a_drain_hold: assert property (p_drain_hold) else $error("entry without refresh"); // [R1]

   property p_ready_busy;
      @(posedge clk) disable iff (!nrst)
      busy |-> !user_ready;
   endproperty
   a_ready_busy: assert property (p_ready_busy) else $error("command during change"); // [R4]

   property p_nop_idle;
      @(posedge clk) disable iff (!nrst)
      !(user_valid && user_ready) |=> cs_n && (ca[2:0] == `CCNOP_NOP_CA);
   endproperty
   a_nop_idle: assert property (p_nop_idle) else $error("idle cycle not a NOP"); // [R4]

   property p_period;
      @(posedge clk) disable iff (!nrst)
      (state_ff == ccnop_pkg::CCNOP_STOP) && !(done_s2_ff && per_s2_ff) |=>
         !ck_run && (state_ff == ccnop_pkg::CCNOP_STOP);
   endproperty
   a_period: assert property (p_period) else $error("resume before period ok"); // [R7]

   property p_exit_len;
      @(posedge clk) disable iff (!nrst)
      $rose(state_ff == ccnop_pkg::CCNOP_RUN) |->
         (since_ck_ff >= CW'(STABLE_TCK + TXP_CYC));
   endproperty
   a_exit_len: assert property (p_exit_len) else $error("exit latency too short"); // [R6]

   property p_mrw_pulse;
      @(posedge clk) disable iff (!nrst)
      mrw_req |=> !mrw_req;
   endproperty
   a_mrw_pulse: assert property (p_mrw_pulse) else $error("mode rewrite not a pulse"); // [R8]

   property p_clk_run;
      @(posedge clk) disable iff (!nrst)
      (state_ff == ccnop_pkg::CCNOP_RUN) |-> ck_run;
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("clock stopped in run"); // [R7]

   property p_busy_stop;
      @(posedge clk) disable iff (!nrst)
      (state_ff == ccnop_pkg::CCNOP_STOP) |-> busy && cs_n;
   endproperty
   a_busy_stop: assert property (p_busy_stop) else $error("stop not flagged busy"); // [R4]
endmodule : ccnop_ctrl

//--- ccnop_dev_model.sv
// Behavioural model of the memory device on the command pins.
// Assumes it shares the controller clock; ck_run gates it.
`timescale 1ns/1ps
module ccnop_dev_model #(
   parameter int RDY_CYC = 4
) (
   input wire logic clk, // Clock
   input wire logic nrst, // Reset, low
   input wire logic ck_run, // Clock running
   input wire logic cs_n, // Select, low
   input wire logic [9:0] ca, // Command bus
   output logic [7:0] cmd_cnt_ff, // Commands seen
   output logic [2:0] burst_ff, // Beats left
   output logic early_ff // Command too soon
);
   logic is_nop;
   logic [3:0] run_ff;
   // =====================
   // Decode and state
   assign is_nop = cs_n | (ca[2:0] == 3'h7);
   // Command and burst counts frozen while stopped; run_ff cleared to zero
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cmd_cnt_ff <= 8'h00;
         burst_ff <= 3'h0;
         early_ff <= 1'h0;
         run_ff <= 4'hf;
      end
      else if (ck_run)
      begin
         run_ff <= (run_ff == 4'hf) ? run_ff : run_ff + 4'h1;
         burst_ff <= (burst_ff == 3'h0) ? 3'h0 : burst_ff - 3'h1;
         if (!is_nop)
         begin
            cmd_cnt_ff <= cmd_cnt_ff + 8'h01;
            burst_ff <= 3'h4;
            early_ff <= early_ff | (int'(run_ff) < RDY_CYC);
         end
      end
      else
         run_ff <= 4'h0;
   end
endmodule : ccnop_dev_model

//--- clock_change_and_nop_handling_tb_top.sv
// Testbench for the clock-change sequencer with a device model.
// Assumes ccnop_ctrl and ccnop_dev_model are compiled first.
`timescale 1ns/1ps
module clock_change_and_nop_handling_tb_top;
   logic clk, nrst, chg_req, chg_done, refresh_ok, ck_period_ok;
   logic user_valid, user_cs_n, user_cke, user_ready, ck_run, ck_t, ck_c;
   logic cs_n, cke, mrw_req, busy, early;
   logic [9:0] user_ca, ca;
   logic [7:0] cmd_cnt;
   logic [2:0] burst;
   int err_count, n_checks, n;
   logic cmds_idle, timing_met, only_refab;
   localparam int W_CK = 0;
   localparam int W_MRW = 1;
   localparam int W_RDY = 2;
   ccnop_ctrl u_ccnop_ctrl (.clk(clk), .nrst(nrst), .chg_req(chg_req),
      .chg_done(chg_done), .refresh_ok(refresh_ok), .cmds_idle(cmds_idle),
      .timing_met(timing_met), .only_refab(only_refab), .ck_period_ok(ck_period_ok),
      .user_valid(user_valid), .user_cs_n(user_cs_n), .user_ca(user_ca),
      .user_cke(user_cke), .user_ready(user_ready), .ck_run(ck_run), .ck_t(ck_t),
      .ck_c(ck_c), .cs_n(cs_n), .ca(ca), .cke(cke), .mrw_req(mrw_req), .busy(busy));
   ccnop_dev_model u_ccnop_dev_model (.clk(clk), .nrst(nrst), .ck_run(ck_run),
      .cs_n(cs_n), .ca(ca), .cmd_cnt_ff(cmd_cnt), .burst_ff(burst), .early_ff(early));
   // =====================
   // Clock and helpers
   initial
   begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (e !== g)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk_bit
   task automatic chk_vec(input string nm, input logic [9:0] e, input logic [9:0] g);
      n_checks++;
      if (e !== g)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk_vec
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   // Wait edges until a signal shows a level; n holds edges used
   function automatic logic pick(input int sel);
      case (sel)
         W_CK: return ck_run;
         W_MRW: return mrw_req;
         default: return user_ready;
      endcase
   endfunction : pick
   task automatic wait_lvl(input int sel, input logic v);
      n = 0;
      while (pick(sel) !== v)
      begin
         @(posedge clk);
         #1;
         n++;
         if (n > 40)
         begin
            err_count++;
            print_verdict();
         end
      end
   endtask : wait_lvl
   task automatic send(input logic c, input logic [9:0] v);
      @(posedge clk);
      user_valid <= 1'h1;
      user_cs_n <= c;
      user_ca <= v;
      #1;
      chk_bit("ready", 1'h1, user_ready);
      @(posedge clk);
      user_valid <= 1'h0;
      #1;
      chk_vec("ca", v, ca);
      chk_bit("cs", c, cs_n);
   endtask : send
   // =====================
   // Scenarios
   task automatic t_cmd;
      send(1'h0, 10'h0a0);
      send(1'h0, 10'h007);
      @(posedge clk);
      #1;
      chk_vec("cmds", 10'h001, {2'h0, cmd_cnt});
      chk_vec("burst", 10'h002, {7'h0, burst});
   endtask : t_cmd
   task automatic t_cke;
      @(posedge clk);
      user_cke <= 1'h0;
      #1;
      chk_bit("cke_refuse", 1'h0, user_ready);
      @(posedge clk);
      user_cke <= 1'h1;
   endtask : t_cke
   task automatic t_change;
      @(posedge clk);
      chg_req <= 1'h1;
      refresh_ok <= 1'h0;
      repeat (4) @(posedge clk);
      #1;
      chk_bit("held_run", 1'h1, ck_run);
      chk_bit("busy", 1'h1, busy);
      chk_bit("ready_busy", 1'h0, user_ready);
      @(posedge clk);
      refresh_ok <= 1'h1;
      cmds_idle <= 1'h0;
      chg_req <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      chk_bit("held_cmds", 1'h1, ck_run);
      @(posedge clk);
      cmds_idle <= 1'h1;
      timing_met <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      chk_bit("held_timing", 1'h1, ck_run);
      @(posedge clk);
      timing_met <= 1'h1;
      only_refab <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      chk_bit("held_refab", 1'h1, ck_run);
      @(posedge clk);
      only_refab <= 1'h1;
      wait_lvl(W_CK, 1'h0);
      chk_bit("cs_idle", 1'h1, cs_n);
      chk_vec("ca_idle", 10'h007, ca);
      chk_vec("park", 10'h001, {8'h0, ck_t, ck_c});
      @(posedge clk);
      chg_done <= 1'h1;
      ck_period_ok <= 1'h0;
      repeat (4) @(posedge clk);
      #1;
      chk_bit("bad_period", 1'h0, ck_run);
      @(posedge clk);
      ck_period_ok <= 1'h1;
      wait_lvl(W_CK, 1'h1);
      wait_lvl(W_MRW, 1'h1);
      chk_bit("ready_late", 1'h1, n >= 4);
      chk_bit("busy_end", 1'h0, busy);
      @(posedge clk);
      chg_done <= 1'h0;
      #1;
      chk_bit("mrw_pulse", 1'h0, mrw_req);
      wait_lvl(W_RDY, 1'h1);
      send(1'h0, 10'h0c1);
      @(posedge clk);
      #1;
      chk_bit("early", 1'h0, early);
      chk_vec("cmds_after", 10'h002, {2'h0, cmd_cnt});
   endtask : t_change
   // =====================
   // Main sequence
   initial
   begin
      {nrst, chg_req, chg_done, user_valid, user_cs_n, user_ca} = '0;
      {refresh_ok, ck_period_ok, user_cke, cmds_idle, timing_met, only_refab} = 6'h3f;
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      #1;
      chk_vec("rst", 10'h02e, {4'h0, ck_run, ck_t, ck_c, cs_n, cke, busy});
      t_cmd();
      t_cke();
      t_change();
      print_verdict();
   end
endmodule : clock_change_and_nop_handling_tb_top
